// *** design/mbsfh_pkg.sv ***
package mbsfh_pkg;
  localparam logic [7:0] TCP_HDR_LEN = 8'h06;
  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [7:0] ADDR_MAX = 8'hF7;
  localparam logic [7:0] FC_NONE = 8'h00;
  localparam logic [7:0] FC_RD_COIL = 8'h01;
  localparam logic [7:0] FC_RD_DIN = 8'h02;
  localparam logic [7:0] FC_RD_HREG = 8'h03;
  localparam logic [7:0] FC_RD_IREG = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_HREG = 8'h06;
  localparam logic [7:0] FC_WR_COILS = 8'h0F;
  localparam logic [7:0] FC_WR_HREGS = 8'h10;
  localparam logic [7:0] FC_ERR_FLAG = 8'h80;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [15:0] COIL_ON = 16'hFF00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [7:0] CRC_LEN = 8'h02;
  localparam logic [7:0] SER_MIN_LEN = 8'h04;
  localparam logic [7:0] PDU_HDR = 8'h02;
  localparam logic [7:0] REQ_MIN = 8'h06;
  localparam logic [7:0] REQ_MULTI_MIN = 8'h07;
  localparam logic [7:0] EXC_LEN = 8'h03;
  localparam int N_COILS = 8;
  localparam int N_DINS = 8;
  localparam int N_HREGS = 8;
  localparam int N_AIN = 8;
  localparam int N_IREGS = 10;
  localparam int BUF_BYTES = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = 10;

  typedef enum logic [2:0] {ST_IDLE, ST_TCP, ST_SER, ST_EXEC, ST_SEND} mbsfh_state_t;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  function automatic logic in_range(input logic [15:0] s, input logic [15:0] q,
                                    input logic [16:0] lim);
    return (q != 16'h0000) && ({1'b0, q} <= lim) && ({1'b0, s} + {1'b0, q} <= lim);
  endfunction

  function automatic logic [7:0] bit_bytes(input logic [15:0] q);
    logic [15:0] t;
    t = (q + 16'h0007) >> 3;
    return t[7:0];
  endfunction
endpackage

// *** design/mbsfh_fifo.sv ***
`timescale 1ns/100ps
module mbsfh_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [W-1:0] od;
  } mbsfh_fifo_t;
  mbsfh_fifo_t r;
  mbsfh_fifo_t next_r;
  logic push;
  logic pop;

  assign in_ready = (r.cnt != (AW+1)'(DEPTH));
  assign out_valid = r.ov;
  assign out_data = r.od;

  always_comb begin
    next_r = r;
    push = in_valid && in_ready;
    // the output register refills as soon as it is consumed, so a full fifo holds DEPTH+1 words
    pop = (r.cnt != '0) && (!r.ov || out_ready);
    if (r.ov && out_ready) begin
      next_r.ov = 1'b0;
    end
    if (pop) begin
      next_r.od = r.mem[r.rp];
      next_r.ov = 1'b1;
      next_r.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
    end
    if (push) begin
      next_r.mem[r.wp] = in_data;
      next_r.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
    end
    next_r.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule // mbsfh_fifo

// *** design/mbsfh_top.sv ***
`timescale 1ns/100ps
module mbsfh_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] station_address,
  input wire logic tcp_rx_valid,
  input wire logic [7:0] tcp_rx_data,
  output logic tcp_rx_ready,
  input wire logic ser_rx_valid,
  input wire logic [7:0] ser_rx_data,
  input wire logic ser_rx_end,
  output logic ser_rx_ready,
  input wire logic [mbsfh_pkg::N_DINS-1:0] digital_input_channel,
  input wire logic [mbsfh_pkg::N_AIN-1:0][15:0] analog_input_value,
  output logic [mbsfh_pkg::N_COILS-1:0] digital_output_channel,
  output logic [mbsfh_pkg::N_HREGS-1:0][15:0] analog_output_value,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic tx_serial,
  input wire logic tx_ready
);
  import mbsfh_pkg::*;

  typedef struct packed {
    mbsfh_state_t st;
    logic pick;
    logic tcp;
    logic bad;
    logic tcp_rdy;
    logic ser_rdy;
    logic [2:0] hcnt;
    logic [7:0] cnt;
    logic [7:0] len;
    logic [15:0] tid;
    logic [15:0] crc;
    logic [BUF_BYTES-1:0][7:0] rx;
    logic [BUF_BYTES-1:0][7:0] tx;
    logic [7:0] tx_len;
    logic [7:0] idx;
    logic [7:0] total;
    logic [N_COILS-1:0] coil;
    logic [N_HREGS-1:0][15:0] hreg;
    logic [31:0] served;
  } mbsfh_regs_t;

  mbsfh_regs_t r;
  mbsfh_regs_t next_r;
  logic tcp_fire;
  logic ser_fire;
  logic push;
  logic [7:0] pbyte;
  logic plast;
  logic fifo_in_ready;
  logic [7:0] addr;
  logic [7:0] fc;
  logic [7:0] exc;
  logic [7:0] plen;
  logic [7:0] hoff;
  logic [15:0] start;
  logic [15:0] qty;
  logic [15:0] w;
  logic [7:0] bits;
  logic [7:0] mask;
  logic [3:0] k;
  logic drop;

  assign tcp_rx_ready = r.tcp_rdy;
  assign ser_rx_ready = r.ser_rdy;
  assign digital_output_channel = r.coil;
  assign analog_output_value = r.hreg;

  always_comb begin
    next_r = r;
    tcp_fire = tcp_rx_valid && r.tcp_rdy;
    ser_fire = ser_rx_valid && r.ser_rdy;
    push = 1'b0;
    pbyte = 8'h00;
    plast = 1'b0;
    addr = r.rx[0];
    fc = r.rx[1];
    start = {r.rx[2], r.rx[3]};
    qty = {r.rx[4], r.rx[5]};
    exc = 8'h00;
    w = 16'h0000;
    bits = 8'h00;
    mask = 8'h00;
    k = 4'h0;
    hoff = r.tcp ? TCP_HDR_LEN : 8'h00;
    plen = r.tcp ? r.cnt : r.cnt - CRC_LEN;
    drop = 1'b0;
    case (r.st)
      ST_IDLE: begin
        // links are offered in turn so a byte is never taken from both at once
        next_r.pick = ~r.pick;
        next_r.cnt = 8'h00;
        next_r.hcnt = 3'h0;
        next_r.bad = 1'b0;
        next_r.crc = CRC_INIT;
        if (tcp_fire) begin
          next_r.tcp = 1'b1;
          next_r.st = ST_TCP;
          next_r.hcnt = 3'h1;
          next_r.tid[15:8] = tcp_rx_data;
        end else if (ser_fire) begin
          next_r.tcp = 1'b0;
          next_r.st = ST_SER;
          next_r.cnt = 8'h01;
          next_r.rx[0] = ser_rx_data;
          next_r.crc = crc_step(CRC_INIT, ser_rx_data);
        end
      end
      ST_TCP: begin
        if (tcp_fire) begin
          if (r.hcnt < TCP_HDR_LEN[2:0]) begin
            next_r.hcnt = r.hcnt + 3'h1;
            case (r.hcnt)
              3'h1: next_r.tid[7:0] = tcp_rx_data;
              3'h2, 3'h3: next_r.bad = r.bad | (tcp_rx_data != 8'h00);
              3'h4: next_r.bad = r.bad | (tcp_rx_data != 8'h00);
              default: begin
                next_r.len = tcp_rx_data;
                if (tcp_rx_data == 8'h00) begin
                  next_r.st = ST_EXEC;
                end
              end
            endcase
          end else begin
            // longer frames than the buffer are swallowed and dropped
            if (r.cnt < 8'(BUF_BYTES)) begin
              next_r.rx[r.cnt[4:0]] = tcp_rx_data;
            end else begin
              next_r.bad = 1'b1;
            end
            next_r.cnt = r.cnt + 8'h01;
            if (r.cnt + 8'h01 == r.len) begin
              next_r.st = ST_EXEC;
            end
          end
        end
      end
      ST_SER: begin
        if (ser_fire) begin
          if (r.cnt < 8'(BUF_BYTES)) begin
            next_r.rx[r.cnt[4:0]] = ser_rx_data;
          end else begin
            next_r.bad = 1'b1;
          end
          if (r.cnt != 8'hFF) begin
            next_r.cnt = r.cnt + 8'h01;
          end
          next_r.crc = crc_step(r.crc, ser_rx_data);
        end
        if (ser_rx_end) begin
          // the residue over data and trailing crc is zero for a good frame
          if (next_r.crc != 16'h0000 || next_r.cnt < SER_MIN_LEN) begin
            next_r.bad = 1'b1;
          end
          next_r.st = ST_EXEC;
        end
      end
      ST_EXEC: begin
        drop = r.bad || plen < PDU_HDR || fc == FC_NONE
          || (addr != ADDR_BCAST && (addr != station_address || addr > ADDR_MAX));
        next_r.tx[0] = addr;
        next_r.tx[1] = fc;
        next_r.tx_len = REQ_MIN;
        for (int i = 2; i < 6; i++) begin
          next_r.tx[i] = r.rx[i];
        end
        case (fc)
          FC_RD_COIL, FC_RD_DIN: begin
            if (plen < REQ_MIN) begin
              exc = EXC_VALUE;
            end else if (!in_range(start, qty, 17'(N_COILS))) begin
              exc = EXC_ADDR;
            end else begin
              bits = (fc == FC_RD_COIL) ? r.coil : digital_input_channel;
              mask = 8'((9'h001 << qty[3:0]) - 9'h001);
              next_r.tx[2] = bit_bytes(qty);
              next_r.tx[3] = (bits >> start[2:0]) & mask;
              next_r.tx_len = EXC_LEN + next_r.tx[2];
            end
          end
          FC_RD_HREG, FC_RD_IREG: begin
            if (plen < REQ_MIN) begin
              exc = EXC_VALUE;
            end else if (!in_range(start, qty, (fc == FC_RD_HREG) ? 17'(N_HREGS)
                                                                    : 17'(N_IREGS))) begin
              exc = EXC_ADDR;
            end else begin
              next_r.tx[2] = {qty[6:0], 1'b0};
              for (int i = 0; i < N_IREGS; i++) begin
                if (16'(i) < qty) begin
                  k = 4'(start + 16'(i));
                  if (fc == FC_RD_HREG) begin
                    w = r.hreg[k[2:0]];
                  end else if (k < 4'(N_AIN)) begin
                    w = analog_input_value[k[2:0]];
                  end else begin
                    // 32-bit served count: low word at the lower register
                    w = (k == 4'(N_AIN)) ? r.served[15:0] : r.served[31:16];
                  end
                  next_r.tx[3 + 2 * i] = w[15:8];
                  next_r.tx[4 + 2 * i] = w[7:0];
                end
              end
              next_r.tx_len = EXC_LEN + next_r.tx[2];
            end
          end
          FC_WR_COIL: begin
            if (plen < REQ_MIN) begin
              exc = EXC_VALUE;
            end else if (!in_range(start, 16'h0001, 17'(N_COILS))) begin
              exc = EXC_ADDR;
            end else if (qty != COIL_ON && qty != COIL_OFF) begin
              exc = EXC_VALUE;
            end else if (!drop) begin
              next_r.coil[start[2:0]] = (qty == COIL_ON);
            end
          end
          FC_WR_HREG: begin
            if (plen < REQ_MIN) begin
              exc = EXC_VALUE;
            end else if (!in_range(start, 16'h0001, 17'(N_HREGS))) begin
              exc = EXC_ADDR;
            end else if (!drop) begin
              next_r.hreg[start[2:0]] = qty;
            end
          end
          FC_WR_COILS: begin
            if (plen < REQ_MULTI_MIN) begin
              exc = EXC_VALUE;
            end else if (!in_range(start, qty, 17'(N_COILS))) begin
              exc = EXC_ADDR;
            end else if (r.rx[6] != bit_bytes(qty) || plen < REQ_MULTI_MIN + r.rx[6]) begin
              exc = EXC_VALUE;
            end else if (!drop) begin
              for (int i = 0; i < N_COILS; i++) begin
                if (16'(i) < qty) begin
                  next_r.coil[3'(start + 16'(i))] = r.rx[7][i];
                end
              end
            end
          end
          FC_WR_HREGS: begin
            if (plen < REQ_MULTI_MIN) begin
              exc = EXC_VALUE;
            end else if (!in_range(start, qty, 17'(N_HREGS))) begin
              exc = EXC_ADDR;
            end else if (r.rx[6] != {qty[6:0], 1'b0} || plen < REQ_MULTI_MIN + r.rx[6]) begin
              exc = EXC_VALUE;
            end else if (!drop) begin
              for (int i = 0; i < N_HREGS; i++) begin
                if (16'(i) < qty) begin
                  next_r.hreg[3'(start + 16'(i))] = {r.rx[7 + 2 * i], r.rx[8 + 2 * i]};
                end
              end
            end
          end
          default: exc = EXC_FUNC;
        endcase
        if (exc != 8'h00) begin
          next_r.tx[1] = fc | FC_ERR_FLAG;
          next_r.tx[2] = exc;
          next_r.tx_len = EXC_LEN;
        end
        next_r.idx = 8'h00;
        next_r.crc = CRC_INIT;
        next_r.total = hoff + next_r.tx_len + (r.tcp ? 8'h00 : CRC_LEN);
        if (!drop) begin
          next_r.served = r.served + 32'h0000_0001;
        end
        // broadcasts are executed but never answered
        next_r.st = (drop || addr == ADDR_BCAST) ? ST_IDLE : ST_SEND;
      end
      ST_SEND: begin
        if (fifo_in_ready) begin
          push = 1'b1;
          if (r.tcp && r.idx < TCP_HDR_LEN) begin
            case (r.idx)
              8'h00: pbyte = r.tid[15:8];
              8'h01: pbyte = r.tid[7:0];
              8'h05: pbyte = r.tx_len;
              default: pbyte = 8'h00;
            endcase
          end else if (r.idx < hoff + r.tx_len) begin
            pbyte = r.tx[5'(r.idx - hoff)];
            next_r.crc = crc_step(r.crc, pbyte);
          end else begin
            pbyte = (r.idx == r.tx_len) ? r.crc[7:0] : r.crc[15:8];
          end
          plast = (r.idx == r.total - 8'h01);
          next_r.idx = r.idx + 8'h01;
          if (plast) begin
            next_r.st = ST_IDLE;
          end
        end
      end
      default: next_r.st = ST_IDLE;
    endcase
    next_r.tcp_rdy = (next_r.st == ST_IDLE && !next_r.pick) || next_r.st == ST_TCP;
    next_r.ser_rdy = (next_r.st == ST_IDLE && next_r.pick) || next_r.st == ST_SER;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // answers are queued so a slow transmitter stalls the sender, and the receiver too while an answer longer than the queue is still being sent
  mbsfh_fifo #(
    .W(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_txq (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_data({~r.tcp, plast, pbyte}),
    .in_ready(fifo_in_ready),
    .out_valid(tx_valid),
    .out_data({tx_serial, tx_last, tx_data}),
    .out_ready(tx_ready)
  );

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  chk_push_only_send: assert property (push |-> r.st == ST_SEND && r.rx[0] != ADDR_BCAST)
    else $error("byte queued outside a reply");
  chk_idle_offers: assert property (r.st == ST_IDLE
    |-> ##[0:1] (tcp_rx_ready || ser_rx_ready))
    else $error("idle without a link ready");
  chk_one_link: assert property (!(tcp_rx_ready && ser_rx_ready))
    else $error("both links offered at once");
  chk_hdr_zero: assert property (push && r.tcp && r.idx inside {8'h02, 8'h03, 8'h04}
    |-> pbyte == 8'h00)
    else $error("tcp header zero byte not zero");
  chk_len_low: assert property (push && r.tcp && r.idx == 8'h05
    |-> pbyte == r.total - TCP_HDR_LEN)
    else $error("tcp length byte wrong");
  chk_fc_echo: assert property (push && r.idx == hoff + 8'h01
    |-> pbyte[6:0] == r.rx[1][6:0])
    else $error("function code not echoed");
  chk_exc_shape: assert property (push && r.idx == hoff + 8'h01 && pbyte[7]
    |-> r.tx_len == EXC_LEN)
    else $error("error reply has wrong length");
  chk_bcast_silent: assert property (r.st == ST_EXEC && r.rx[0] == ADDR_BCAST
    |=> r.st == ST_IDLE ##1 !push)
    else $error("broadcast answered");
  chk_bad_crc: assert property (r.st == ST_EXEC && !r.tcp && r.bad
    |=> r.st == ST_IDLE)
    else $error("bad serial frame not dropped");
  chk_coil_cause: assert property ($changed(digital_output_channel)
    |-> $past(r.st) == ST_EXEC)
    else $error("outputs changed without a write");
endmodule // mbsfh_top

// *** test/mbsfh_tb_pkg.sv ***
package mbsfh_tb_pkg;
  typedef logic [7:0] mbsfh_bq_t[$];

  // lowest n bytes of v, most significant first
  function automatic mbsfh_bq_t bq(input logic [127:0] v, input int n);
    mbsfh_bq_t q;
    for (int i = n - 1; i >= 0; i--) q.push_back(v[8*i+:8]);
    return q;
  endfunction
endpackage

// *** test/mbsfh_master.sv ***
`timescale 1ns/100ps
module mbsfh_master
  import mbsfh_tb_pkg::*;
(
  input wire logic ref_clk,
  output logic tcp_rx_valid,
  output logic [7:0] tcp_rx_data,
  input wire logic tcp_rx_ready,
  output logic ser_rx_valid,
  output logic [7:0] ser_rx_data,
  output logic ser_rx_end,
  input wire logic ser_rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_serial,
  output logic tx_ready
);
  // stalling every other cycle makes the fifo back up
  logic slow;
  int lost;
  initial begin
    tcp_rx_valid = 1'b0;
    tcp_rx_data = 8'h00;
    ser_rx_valid = 1'b0;
    ser_rx_data = 8'h00;
    ser_rx_end = 1'b0;
    tx_ready = 1'b0;
    slow = 1'b0;
    lost = 0;
  end

  function automatic logic [15:0] crc16(input mbsfh_bq_t q);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction

  function automatic mbsfh_bq_t tcp_frame(input logic [15:0] tid, input mbsfh_bq_t pdu);
    mbsfh_bq_t q;
    q = {tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'(pdu.size()), pdu};
    return q;
  endfunction

  function automatic mbsfh_bq_t ser_frame(input mbsfh_bq_t pdu);
    logic [15:0] c;
    mbsfh_bq_t q;
    c = crc16(pdu);
    q = {pdu, c[7:0], c[15:8]};
    return q;
  endfunction

  // only this side opens a transaction; gives up if the byte is never taken
  task automatic send(input logic ser, input mbsfh_bq_t q);
    int w;
    foreach (q[i]) begin
      tcp_rx_valid <= !ser;
      tcp_rx_data <= q[i];
      ser_rx_valid <= ser;
      ser_rx_data <= q[i];
      w = 0;
      @(posedge ref_clk);
      while ((ser ? ser_rx_ready : tcp_rx_ready) !== 1'b1 && w < 100) begin
        w++;
        @(posedge ref_clk);
      end
      if (w == 100) lost++;
    end
    tcp_rx_valid <= 1'b0;
    ser_rx_valid <= 1'b0;
    tcp_rx_data <= ~tcp_rx_data;
    ser_rx_data <= ~ser_rx_data;
    if (ser) begin
      ser_rx_end <= 1'b1;
      @(posedge ref_clk);
      ser_rx_end <= 1'b0;
    end
  endtask

  task automatic recv(output mbsfh_bq_t q, output logic ser);
    int n;
    q = {};
    ser = 1'b0;
    n = 0;
    while (n < 400) begin
      tx_ready <= slow ? n[0] : 1'b1;
      @(posedge ref_clk);
      n++;
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        q.push_back(tx_data);
        ser = tx_serial;
        if (tx_last === 1'b1) n = 400;
      end
    end
    tx_ready <= 1'b0;
  endtask

  task automatic quiet(output int seen);
    seen = 0;
    tx_ready <= 1'b1;
    repeat (30) begin
      @(posedge ref_clk);
      if (tx_valid !== 1'b0) seen++;
    end
    tx_ready <= 1'b0;
  endtask
endmodule // mbsfh_master

// *** test/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  import mbsfh_pkg::*;
  import mbsfh_tb_pkg::*;
  logic ref_clk, rst_n, tcp_rx_valid, tcp_rx_ready, ser_rx_valid, ser_rx_end, ser_rx_ready;
  logic tx_valid, tx_last, tx_serial, tx_ready;
  logic [7:0] station_address, tcp_rx_data, ser_rx_data, tx_data;
  logic [N_DINS-1:0] digital_input_channel;
  logic [N_AIN-1:0][15:0] analog_input_value;
  logic [N_COILS-1:0] digital_output_channel;
  logic [N_HREGS-1:0][15:0] analog_output_value;
  logic [15:0] tid;
  int fail_count = 0;
  int checks = 0;

  mbsfh_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .station_address(station_address),
    .tcp_rx_valid(tcp_rx_valid), .tcp_rx_data(tcp_rx_data), .tcp_rx_ready(tcp_rx_ready),
    .ser_rx_valid(ser_rx_valid), .ser_rx_data(ser_rx_data), .ser_rx_end(ser_rx_end),
    .ser_rx_ready(ser_rx_ready), .digital_input_channel(digital_input_channel),
    .analog_input_value(analog_input_value), .digital_output_channel(digital_output_channel),
    .analog_output_value(analog_output_value), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_serial(tx_serial), .tx_ready(tx_ready));

  mbsfh_master m_u (.ref_clk(ref_clk), .tcp_rx_valid(tcp_rx_valid), .tcp_rx_data(tcp_rx_data),
    .tcp_rx_ready(tcp_rx_ready), .ser_rx_valid(ser_rx_valid), .ser_rx_data(ser_rx_data),
    .ser_rx_end(ser_rx_end), .ser_rx_ready(ser_rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_serial(tx_serial), .tx_ready(tx_ready));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic cmp_v(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_q(input mbsfh_bq_t got, input mbsfh_bq_t exp);
    checks++;
    if (got.size() != exp.size()) begin
      fail_count++;
      $display("mismatch at %0t length got %h exp %h", $time, got.size(), exp.size());
    end else begin
      foreach (exp[i]) if (got[i] !== exp[i]) begin
        fail_count++;
        $display("mismatch at %0t byte %0d got %h exp %h", $time, i, got[i], exp[i]);
        break;
      end
    end
  endtask

  // one request, one framed answer, compared whole
  task automatic xact(input logic ser, input mbsfh_bq_t pdu, input mbsfh_bq_t rsp);
    mbsfh_bq_t got;
    logic gs;
    if (ser) m_u.send(ser, m_u.ser_frame(pdu));
    else m_u.send(ser, m_u.tcp_frame(tid, pdu));
    m_u.recv(got, gs);
    if (ser) cmp_q(got, m_u.ser_frame(rsp));
    else cmp_q(got, m_u.tcp_frame(tid, rsp));
    cmp_v({15'h0000, gs}, {15'h0000, ser});
    cmp_v(16'(m_u.lost), 16'h0000);
  endtask

  // frame that must vanish without any answer
  task automatic drop(input logic ser, input mbsfh_bq_t f);
    int seen;
    m_u.send(ser, f);
    m_u.quiet(seen);
    cmp_v(16'(seen), 16'h0000);
  endtask

  task automatic t_coils();
    xact(1'b1, bq(128'h11050001FF00, 6), bq(128'h11050001FF00, 6));
    cmp_v({8'h00, digital_output_channel}, 16'h0002);
    xact(1'b0, bq(128'h110F0000000801A5, 8), bq(128'h110F00000008, 6));
    cmp_v({8'h00, digital_output_channel}, 16'h00A5);
    tid = 16'hFFFE;
    xact(1'b0, bq(128'h110100010003, 6), bq(128'h11010102, 4));
    xact(1'b1, bq(128'h110100000008, 6), bq(128'h110101A5, 4));
    $display("test coils done");
  endtask

  task automatic t_din();
    digital_input_channel <= 8'h3C;
    @(posedge ref_clk);
    xact(1'b1, bq(128'h110200020004, 6), bq(128'h1102010F, 4));
    $display("test discrete inputs done");
  endtask

  task automatic t_regs();
    m_u.slow = 1'b1;
    analog_input_value[0] <= 16'hC0DE;
    analog_input_value[1] <= 16'h0A0B;
    xact(1'b0, bq(128'h110600020A0B, 6), bq(128'h110600020A0B, 6));
    cmp_v(analog_output_value[2], 16'h0A0B);
    xact(1'b0, bq(128'h1110000500020412345678, 11), bq(128'h111000050002, 6));
    cmp_v(analog_output_value[5], 16'h1234);
    cmp_v(analog_output_value[6], 16'h5678);
    xact(1'b1, bq(128'h110300050002, 6), bq(128'h11030412345678, 7));
    xact(1'b0, bq(128'h110400000002, 6), bq(128'h110404C0DE0A0B, 7));
    xact(1'b0, bq(128'h110400080002, 6), bq(128'h11040400090000, 7));
    m_u.slow = 1'b0;
    $display("test registers done");
  endtask

  task automatic t_exc();
    mbsfh_bq_t req[5];
    mbsfh_bq_t rsp[5];
    req = '{bq(128'h110700000001, 6), bq(128'h110100000000, 6), bq(128'h110100070002, 6),
            bq(128'h1101, 2), bq(128'h110500001234, 6)};
    rsp = '{bq(128'h118701, 3), bq(128'h118102, 3), bq(128'h118102, 3),
            bq(128'h118103, 3), bq(128'h118503, 3)};
    foreach (req[i]) xact(1'b0, req[i], rsp[i]);
    cmp_v({8'h00, digital_output_channel}, 16'h00A5);
    $display("test exceptions done");
  endtask

  task automatic t_drop();
    mbsfh_bq_t f;
    drop(1'b0, m_u.tcp_frame(tid, bq(128'h220100000008, 6)));
    drop(1'b0, m_u.tcp_frame(tid, bq(128'h110000000001, 6)));
    drop(1'b0, bq(128'h010200010006110100000008, 12));
    station_address <= 8'hF8;
    drop(1'b0, m_u.tcp_frame(tid, bq(128'hF80100000008, 6)));
    station_address <= 8'h11;
    f = m_u.ser_frame(bq(128'h110100000008, 6));
    f[7] = ~f[7];
    drop(1'b1, f);
    drop(1'b0, m_u.tcp_frame(tid, bq(128'h00050006FF00, 6)));
    cmp_v({8'h00, digital_output_channel}, 16'h00E5);
    drop(1'b1, m_u.ser_frame(bq(128'h000100000008, 6)));
    xact(1'b1, bq(128'h110100000008, 6), bq(128'h110101E5, 4));
    $display("test silent drops done");
  endtask

  task automatic wrap_up();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // all tests need well under 10000 cycles
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    station_address = 8'h11;
    digital_input_channel = 8'h00;
    analog_input_value = '0;
    tid = 16'h0102;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_coils();
    t_din();
    t_regs();
    t_exc();
    t_drop();
    wrap_up();
  end
endmodule // testbench
